// >>> core/spl_pkg.sv
// Constants, register map and carrier types of the byte-wide serial port.
// Assumes a single 250 MHz clock and an AXI4-Lite master with 8-bit byte addresses.
package spl_pkg;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [7:0] IDX_DATA = 8'h31;
   localparam logic [7:0] IDX_CTRL = 8'h32;
   localparam logic [7:0] IDX_CSR = 8'h33;
   localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 4);
   localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL * 4);
   localparam logic [7:0] ADDR_CSR = 8'(IDX_CSR * 4);

   localparam int CR_IE = 7;
   localparam int CR_PE = 6;
   localparam int CR_R2 = 5;
   localparam int CR_MS = 4;
   localparam int CR_IDLE_LEVEL_SELECT = 3;
   localparam int CR_CAPTURE_PHASE_SELECT = 2;
   localparam int CR_R1 = 1;
   localparam int CR_R0 = 0;
   localparam int CS_SOD = 2;
   localparam int CS_SSM = 1;
   localparam int CS_SSI = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] CSR_SW_RST = 3'h0;
   localparam logic [7:0] DATA_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Half periods of SCK in clock cycles
   localparam logic [6:0] HALF_DIV4 = 7'h02;
   localparam logic [6:0] HALF_DIV8 = 7'h04;
   localparam logic [6:0] HALF_DIV16 = 7'h08;
   localparam logic [6:0] HALF_DIV32 = 7'h10;
   localparam logic [6:0] HALF_DIV64 = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [1:0] {SEL_NONE = 2'b00, SEL_DATA = 2'b01, SEL_CTRL = 2'b10, SEL_CSR = 2'b11} spl_sel_e;
   typedef enum logic {ST_IDLE = 1'b0, ST_SHIFT = 1'b1} spl_state_e;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } spl_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } spl_axi_rsp_s;
endpackage

// >>> core/spl_core.sv
// Byte-wide serial peripheral, master or slave, with its three registers.
// Assumes pins arrive asynchronously and a pad ring resolves the enables.
//
// Overview of operation
// - Interrupt when enabled and done, overrun or fault
// - Port enable resets low, fault clears it
// - Master SCK rate from three rate bits
// - Rate bits ignored in slave mode
// - Master drives SCK, swaps data pins
// - Idle level bit sets SCK idle level
// - Phase bit picks first capture edge
// - Done flag set, cleared by status-then-data
// - Data writes ignored while done flag unread
// - Data write while shifting sets clash flag
// - Overrun set on done while done set
// - Fault on select low in master mode
// - Output disable releases data output pin
// - Soft select source ignores select pin
// - Soft select level zero means selected
// - Master data write starts one byte
// - Received byte copied to buffer on completion
// - Registers at indices 31, 32, 33
// - Fault blocks setting enable and master bits
// - Overrun keeps first byte, drops later ones
// - Clash leaves transfer alone, no interrupt
//
// Our own choice: the AXI4-Lite slave port.
module spl_core
   import spl_pkg::*;
(
   input logic clk,
   input logic rst_n,
   input spl_axi_req_s axi_req,
   output spl_axi_rsp_s axi_rsp,
   input logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   input logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input logic ss_n_i,
   output logic port_en,
   output logic irq
);

   function automatic spl_sel_e reg_sel(input logic [7:0] a);
      case (a)
         ADDR_DATA: reg_sel = SEL_DATA;
         ADDR_CTRL: reg_sel = SEL_CTRL;
         ADDR_CSR: reg_sel = SEL_CSR;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   function automatic logic [6:0] rate_half(input logic [2:0] r);
      case (r)
         3'b100: rate_half = HALF_DIV4;
         3'b000: rate_half = HALF_DIV8;
         3'b001: rate_half = HALF_DIV16;
         3'b110: rate_half = HALF_DIV32;
         3'b010: rate_half = HALF_DIV64;
         3'b011: rate_half = HALF_DIV128;
         default: rate_half = HALF_DIV4;
      endcase
   endfunction

   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [2:0] csr_sw;
   logic transfer_done_flag, write_clash_flag, overrun_flag, mf, armed, mf_armed;
   logic [3:0] pin_m, pin_s;
   logic sck_p;
   logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
   logic [1:0] bresp, rresp;
   logic [7:0] aw_q, wd_q, rdata, rd_val;
   logic wstb_q;
   spl_state_e state;
   logic [2:0] cnt;
   logic [6:0] hcnt, half;
   logic sck_lvl, dout, rx_lat;
   logic [7:0] shreg, next_shreg, rxbuf;
   logic [1:0] cap_d, fin_d;
   logic [7:0] rx_sh, next_rx_sh;
   logic ie, pe, controller_role_bit, idle_level_select, capture_phase_select, out_drive_off, select_source_soft, soft_select_level;
   logic wr_go, rd_go, dw, cw, sw, data_rd, csr_rd, data_acc;
   spl_sel_e wsel, rsel;
   logic ss_int, sel_act, tick, lead, trail, din, done, wr_ok, dw_take, collide, fault;

   assign ie = ctrl[CR_IE];
   assign pe = ctrl[CR_PE];
   assign controller_role_bit = ctrl[CR_MS];
   assign idle_level_select = ctrl[CR_IDLE_LEVEL_SELECT];
   assign capture_phase_select = ctrl[CR_CAPTURE_PHASE_SELECT];
   assign out_drive_off = csr_sw[CS_SOD];
   assign select_source_soft = csr_sw[CS_SSM];
   assign soft_select_level = csr_sw[CS_SSI];
   assign half = rate_half({ctrl[CR_R2], ctrl[CR_R1], ctrl[CR_R0]});

   assign axi_rsp = '{awready: aw_rdy, wready: w_rdy, bvalid: bvalid, bresp: bresp,
                      arready: ar_rdy, rvalid: rvalid, rdata: {24'h000000, rdata}, rresp: rresp};

   // Register bus decode
   assign wr_go = !aw_rdy && !w_rdy && !bvalid;
   assign wsel = reg_sel(aw_q);
   assign rsel = reg_sel(axi_req.araddr);
   assign rd_go = axi_req.arvalid && ar_rdy;
   assign dw = wr_go && wsel == SEL_DATA && wstb_q;
   assign cw = wr_go && wsel == SEL_CTRL && wstb_q;
   assign sw = wr_go && wsel == SEL_CSR && wstb_q;
   assign data_rd = rd_go && rsel == SEL_DATA;
   assign csr_rd = rd_go && rsel == SEL_CSR;
   assign data_acc = dw || data_rd;

   // Serial engine decode
   assign ss_int = select_source_soft ? soft_select_level : pin_s[0];
   assign sel_act = pe && !controller_role_bit && !ss_int;
   assign tick = controller_role_bit && state == ST_SHIFT && hcnt == 7'h00;
   assign lead = controller_role_bit ? (tick && sck_lvl == idle_level_select) : (sel_act && pin_s[3] != sck_p && sck_p == idle_level_select);
   assign trail = controller_role_bit ? (tick && sck_lvl != idle_level_select) : (sel_act && pin_s[3] != sck_p && sck_p != idle_level_select);
   assign din = controller_role_bit ? pin_s[1] : pin_s[2];
   assign done = trail && state == ST_SHIFT && cnt == LAST_BIT;
   assign next_shreg = {shreg[6:0], capture_phase_select ? din : rx_lat};
   // Master capture runs two cycles late to match the pin synchroniser
   assign next_rx_sh = cap_d[1] ? {rx_sh[6:0], pin_s[1]} : rx_sh;
   assign wr_ok = !(transfer_done_flag && !armed);
   assign dw_take = dw && wr_ok && state == ST_IDLE;
   assign collide = dw && wr_ok && state == ST_SHIFT;
   assign fault = controller_role_bit && !ss_int;

   // Two-flop synchronisers for the pins: {sck, mosi, miso, ss_n}
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_m <= 4'hF;
         pin_s <= 4'hF;
         sck_p <= 1'b1;
      end
      else
      begin
         pin_m <= {sck_i, mosi_i, miso_i, ss_n_i};
         pin_s <= pin_m;
         sck_p <= pin_s[3];
      end
   end

   // Write channels: address and data taken in either order
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         aw_rdy <= 1'b1;
         w_rdy <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_q <= 8'h00;
         wd_q <= 8'h00;
         wstb_q <= 1'b0;
      end
      else
      begin
         if (axi_req.awvalid && aw_rdy)
         begin
            aw_q <= axi_req.awaddr;
            aw_rdy <= 1'b0;
         end
         if (axi_req.wvalid && w_rdy)
         begin
            wd_q <= axi_req.wdata[7:0];
            wstb_q <= axi_req.wstrb[0];
            w_rdy <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid <= 1'b1;
            bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (bvalid && axi_req.bready)
         begin
            bvalid <= 1'b0;
            aw_rdy <= 1'b1;
            w_rdy <= 1'b1;
         end
      end
   end

   always_comb
   begin
      case (rsel)
         SEL_DATA: rd_val = rxbuf;
         SEL_CTRL: rd_val = ctrl;
         SEL_CSR: rd_val = {transfer_done_flag, write_clash_flag, overrun_flag, mf, 1'b0, csr_sw};
         default: rd_val = 8'h00;
      endcase
   end

   // Read channel; reading has side effects on the flag sequences
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ar_rdy <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 8'h00;
         rresp <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         ar_rdy <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_val;
         rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid && axi_req.rready)
      begin
         rvalid <= 1'b0;
         ar_rdy <= 1'b1;
      end
   end

   always_comb
   begin
      next_ctrl = ctrl;
      if (cw)
      begin
         next_ctrl = wd_q;
         if (mf && !mf_armed)
         begin
            next_ctrl[CR_PE] = 1'b0;
            next_ctrl[CR_MS] = 1'b0;
         end
      end
      if (fault)
      begin
         next_ctrl[CR_PE] = 1'b0;
         next_ctrl[CR_MS] = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl <= CTRL_RST;
         csr_sw <= CSR_SW_RST;
      end
      else
      begin
         ctrl <= next_ctrl;
         if (sw)
         begin
            csr_sw <= wd_q[2:0];
         end
      end
   end

   // Status flags; a hardware set always beats a software clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         transfer_done_flag <= 1'b0;
         write_clash_flag <= 1'b0;
         overrun_flag <= 1'b0;
         mf <= 1'b0;
         armed <= 1'b0;
         mf_armed <= 1'b0;
      end
      else
      begin
         if (done)
            transfer_done_flag <= 1'b1;
         else if (data_acc && armed)
            transfer_done_flag <= 1'b0;
         if (collide)
            write_clash_flag <= 1'b1;
         else if (data_acc && armed)
            write_clash_flag <= 1'b0;
         if (done && transfer_done_flag)
            overrun_flag <= 1'b1;
         else if (csr_rd)
            overrun_flag <= 1'b0;
         if (fault)
            mf <= 1'b1;
         else if (cw && mf_armed)
            mf <= 1'b0;
         if (data_acc)
            armed <= 1'b0;
         else if (csr_rd && (transfer_done_flag || write_clash_flag))
            armed <= 1'b1;
         if (cw)
            mf_armed <= 1'b0;
         else if (csr_rd && mf)
            mf_armed <= 1'b1;
      end
   end

   // Sequencing; a lost select or enable aborts the byte
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         hcnt <= 7'h00;
      end
      else if (!pe || fault || (!controller_role_bit && ss_int))
      begin
         state <= ST_IDLE;
         cnt <= 3'h0;
      end
      else if (state == ST_IDLE)
      begin
         if (controller_role_bit ? dw_take : lead)
         begin
            state <= ST_SHIFT;
            hcnt <= half - 7'h01;
            cnt <= 3'h0;
         end
      end
      else
      begin
         if (tick)
            hcnt <= half - 7'h01;
         else if (controller_role_bit)
            hcnt <= hcnt - 7'h01;
         if (trail)
            cnt <= cnt + 3'h1;
         if (done)
            state <= ST_IDLE;
      end
   end

   // Master clock; rests at the idle level between bytes
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sck_lvl <= 1'b0;
      else if (state == ST_SHIFT && tick)
         sck_lvl <= ~sck_lvl;
      else if (state == ST_IDLE)
         sck_lvl <= idle_level_select;
   end

   // Shifter: phase 0 samples on lead, phase 1 drives on lead
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         shreg <= DATA_RST;
         rx_lat <= 1'b0;
         dout <= 1'b0;
         rxbuf <= DATA_RST;
      end
      else
      begin
         if (dw_take)
            shreg <= wd_q;
         else if (trail)
            shreg <= next_shreg;
         if (lead && !capture_phase_select)
            rx_lat <= din;
         if (lead && capture_phase_select)
            dout <= shreg[7];
         else if (trail && !capture_phase_select)
            dout <= shreg[6];
         else if (state == ST_IDLE)
            dout <= dw_take ? wd_q[7] : shreg[7];
         if (done && !transfer_done_flag && !controller_role_bit)
            rxbuf <= next_shreg;
         else if (fin_d[1])
            rxbuf <= next_rx_sh;
      end
   end

   // Delayed master receive path; without it a fast SCK samples a stale bit
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cap_d <= 2'b00;
         fin_d <= 2'b00;
         rx_sh <= DATA_RST;
      end
      else
      begin
         cap_d <= {cap_d[0], controller_role_bit && (capture_phase_select ? trail : lead)};
         fin_d <= {fin_d[0], controller_role_bit && done && !transfer_done_flag};
         rx_sh <= next_rx_sh;
      end
   end

   // Pin drivers and interrupt, all registered
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sck_oe <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         port_en <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         sck_oe <= pe && controller_role_bit;
         mosi_oe <= pe && controller_role_bit && !out_drive_off;
         miso_oe <= pe && !controller_role_bit && !out_drive_off && !ss_int;
         port_en <= pe;
         irq <= ie && (transfer_done_flag || overrun_flag || mf);
      end
   end

   assign sck_o = sck_lvl;
   assign mosi_o = dout;
   assign miso_o = dout;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_irq_gate: assert property (##1 irq == $past(ie && (transfer_done_flag || overrun_flag || mf)))
      else $error("irq does not follow enable and flags");
   a_pe_reset: assert property ($rose(rst_n) |-> !pe && !port_en && !controller_role_bit)
      else $error("port enable not low after reset");
   a_fault_clear: assert property (fault |=> !pe && !controller_role_bit && mf ##1 !port_en && !sck_oe)
      else $error("mode fault did not clear enable and role");
   a_rate_tick: assert property (tick && !done && $stable(ctrl) |=> hcnt == half - 7'h01)
      else $error("SCK half period reload wrong");
   a_sck_idle: assert property ((state == ST_IDLE && $stable(idle_level_select)) [*2] |-> sck_o == idle_level_select)
      else $error("SCK not at idle level");
   a_done_flag: assert property (done |=> transfer_done_flag && state == ST_IDLE)
      else $error("transfer done flag not set");
   a_write_block: assert property (dw && transfer_done_flag && !armed && state == ST_IDLE |=> state == ST_IDLE)
      else $error("blocked data write started a byte");
   a_write_clash_flag_set: assert property (collide |=> write_clash_flag && !irq ##0 $stable(state))
      else $error("write collision not flagged");
   a_ovr_keep: assert property (done && transfer_done_flag |=> overrun_flag && $stable(rxbuf))
      else $error("overrun lost or buffer overwritten");
   a_sod_off: assert property (out_drive_off |=> !mosi_oe && !miso_oe)
      else $error("data output driven while disabled");
   a_master_start: assert property (dw_take && controller_role_bit && pe && !fault |=> state == ST_SHIFT && shreg == $past(wd_q))
      else $error("master write did not start a byte");
endmodule

// >>> bench/spl_partner.sv
// Far-end slave model for master-mode transfers.
// Assumes SCK is pulled to the idle level while the device releases it.
module spl_partner
(
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic idle_level_select,
   input wire logic capture_phase_select,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   always @(negedge sel_n)
   begin
      sh = tx;
      miso = tx[7];
   end
   // Released line inverts so a stale bit never passes
   always @(posedge sel_n) miso = ~miso;
   always @(sck)
   begin
      if (!sel_n && (sck != idle_level_select) != capture_phase_select)
         rx = {rx[6:0], mosi};
      else if (!sel_n)
      begin
         if (!capture_phase_select)
            sh = sh << 1;
         miso = sh[7];
         if (capture_phase_select)
            sh = sh << 1;
      end
   end
endmodule

// >>> bench/spi_master_slave_regs_tb.sv
// Bench for the serial port: bus tasks, master, fault and slave scenarios.
// Assumes the far-end slave model and a select pin pulled high.
module spi_master_slave_regs_tb
   import spl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, ss_n, ext_sck, ext_mosi, p_sel_n, pcpha, ls, so;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_w, port_en, irq;
   logic [7:0] p_tx, p_rx, rd, ctl, sg;
   logic [1:0] rs;
   spl_axi_req_s req;
   spl_axi_rsp_s rsp;
   int mismatches, checks_done, i, e0, cnt, half;
   int edges = 0;
   int dv[8] = '{8, 16, 64, 128, 4, 4, 32, 4};
   wire sck_w = sck_oe ? sck_o : ext_sck;

   spl_core u_spl_core (.clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .sck_i(sck_w), .sck_o(sck_o),
      .sck_oe(sck_oe), .mosi_i(ext_mosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
      .miso_oe(miso_oe), .ss_n_i(ss_n), .port_en(port_en), .irq(irq));
   spl_partner u_spl_partner (.sck(sck_w), .mosi(mosi_o), .sel_n(p_sel_n), .idle_level_select(ext_sck), .capture_phase_select(pcpha),
      .tx(p_tx), .miso(miso_w), .rx(p_rx));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Half period of SCK in clock cycles, last one seen
   always @(sck_o) edges++;
   always @(posedge clk)
   begin
      ls <= sck_o;
      cnt <= (sck_o != ls) ? 1 : cnt + 1;
      if (sck_o != ls)
         half <= cnt;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic hang();
      mismatches++;
      tally_and_finish();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h000000, d};
      req.bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (rsp.awready)
            req.awvalid <= 1'b0;
         if (rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid)
            break;
      end
      req.bready <= 1'b0;
      rs = rsp.bresp;
      if (n == 40)
         hang();
   endtask

   task automatic rdr(input logic [7:0] a);
      int n;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid)
            break;
      end
      req.rready <= 1'b0;
      rd = rsp.rdata[7:0];
      rs = rsp.rresp;
      if (n == 40)
         hang();
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
      rdr(a);
      chk(nm, rd, e);
   endtask

   task automatic wait_irq();
      int n;
      for (n = 0; n < 2000 && irq !== 1'b1; n++)
         @(posedge clk);
      if (n == 2000)
         hang();
   endtask

   // Bench acts as external master, idle low, capture on lead edge
   task automatic sx(input logic [7:0] b);
      int k;
      @(posedge clk);
      ss_n <= 1'b0;
      for (k = 7; k >= 0; k--)
      begin
         ext_mosi <= b[k];
         repeat (8) @(posedge clk);
         ext_sck <= 1'b1;
         sg[k] = miso_o;
         so = miso_oe;
         repeat (8) @(posedge clk);
         ext_sck <= 1'b0;
      end
      repeat (8) @(posedge clk);
      ss_n <= 1'b1;
   endtask

   initial
   begin
      req = '0;
      req.wstrb = 4'hF;
      rst_n = 1'b0;
      ss_n = 1'b1;
      ext_sck = 1'b0;
      ext_mosi = 1'b0;
      p_sel_n = 1'b1;
      pcpha = 1'b0;
      p_tx = 8'h00;
      mismatches = 0;
      checks_done = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rdr(ADDR_CTRL);
      chk("ctrl", rd[7:4], 4'h0);
      rc(ADDR_CSR, 8'h00, "csr");
      rdr(8'h00);
      chk("rresp", rs, RESP_SLVERR);
      for (i = 0; i < 8; i++)
      begin
         ctl = {2'b10, i[2], 1'b1, i[1], i[0], i[1:0]};
         ext_sck <= i[1];
         pcpha <= i[0];
         wr(ADDR_CTRL, ctl);
         wr(ADDR_CTRL, ctl | 8'h40);
         repeat (2) @(posedge clk);
         chk("oe", {port_en, sck_oe, mosi_oe, sck_o}, {3'h7, i[1]});
         p_tx <= 8'h3C + 8'(i);
         p_sel_n <= 1'b0;
         wr(ADDR_DATA, 8'hA5 ^ 8'(i));
         wait_irq();
         chk("half", half, dv[i] / 2);
         chk("p_rx", p_rx, 8'hA5 ^ 8'(i));
         chk("idle", sck_o, i[1]);
         p_sel_n <= 1'b1;
         rc(ADDR_CSR, 8'h80, "csr");
         rc(ADDR_DATA, 8'h3C + 8'(i), "data");
         rc(ADDR_CSR, 8'h00, "csr");
         wr(ADDR_CTRL, ctl);
      end
      ext_sck <= 1'b0;
      pcpha <= 1'b0;
      wr(ADDR_CTRL, 8'hB0);
      wr(ADDR_CTRL, 8'hF0);
      p_tx <= 8'h5A;
      p_sel_n <= 1'b0;
      wr(ADDR_DATA, 8'hC3);
      wr(ADDR_DATA, 8'h11);
      chk("irq", irq, 1'b0);
      wait_irq();
      chk("p_rx", p_rx, 8'hC3);
      e0 = edges;
      wr(ADDR_DATA, 8'h77);
      repeat (8) @(posedge clk);
      chk("edges", edges, e0);
      p_sel_n <= 1'b1;
      rc(ADDR_CSR, 8'hC0, "csr");
      rc(ADDR_DATA, 8'h5A, "data");
      rc(ADDR_CSR, 8'h00, "csr");
      ss_n <= 1'b0;
      wait_irq();
      ss_n <= 1'b1;
      @(posedge clk);
      chk("pins", {port_en, sck_oe}, 2'b00);
      rc(ADDR_CTRL, 8'hA0, "ctrl");
      wr(ADDR_CTRL, 8'hF0);
      rc(ADDR_CTRL, 8'hA0, "ctrl");
      rc(ADDR_CSR, 8'h10, "csr");
      wr(ADDR_CTRL, 8'hF0);
      rc(ADDR_CSR, 8'h00, "csr");
      rc(ADDR_CTRL, 8'hF0, "ctrl");
      wr(ADDR_CSR, 8'h07);
      ss_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("mosi_oe", mosi_oe, 1'b0);
      rc(ADDR_CSR, 8'h07, "csr");
      wr(ADDR_CSR, 8'h02);
      wait_irq();
      rc(ADDR_CSR, 8'h12, "csr");
      wr(ADDR_CTRL, 8'h00);
      rc(ADDR_CSR, 8'h02, "csr");
      ss_n <= 1'b1;
      wr(ADDR_CSR, 8'h00);
      wr(ADDR_CTRL, 8'hE3);
      chk("sck_oe", sck_oe, 1'b0);
      wr(ADDR_DATA, 8'h96);
      sx(8'h69);
      chk("miso", {so, sg}, {1'b1, 8'h96});
      sx(8'h5B);
      chk("irq", irq, 1'b1);
      rc(ADDR_CSR, 8'hA0, "csr");
      rc(ADDR_DATA, 8'h69, "data");
      rc(ADDR_CSR, 8'h00, "csr");
      tally_and_finish();
   end
endmodule
